// ### src/atard_read_cmd.sv
// Read command interpreter of the drive: task file, sector fetch, DMA and PIO data-in
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "atard_cfg.svh"
module atard_read_cmd (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             intrq,
  output logic             dmarq,
  input  wire logic        dmack_n,
  input  wire logic        iord_n,
  output logic      [15:0] dd_out,
  output logic             dd_oe,
  output logic             media_req,
  output logic      [47:0] media_lba,
  output logic             media_fua,
  input  wire logic        media_valid,
  input  wire logic [15:0] media_data,
  input  wire logic        media_err,
  output logic             flush_req,
  input  wire logic        flush_done,
  output logic             busy
);

  atard_pkg::atard_regs_t q;
  atard_pkg::atard_regs_t next_q;
  logic [15:0]            buf_word;
  logic                   buf_wr;
  logic                   iord_fall;
  logic                   dmack_on;
  logic [7:0]             status;
  logic [27:0]            lba28;
  logic [47:0]            lba48;
  logic [15:0]            qcount;

  // ----------------------------------------------------------------
  // Address write-back into the task file
  // ----------------------------------------------------------------
  function automatic atard_pkg::atard_regs_t put_addr(input atard_pkg::atard_regs_t s);
    atard_pkg::atard_regs_t r;
    r = s;
    r.lo = s.lba[7:0];
    r.mid = s.lba[15:8];
    r.hi = s.lba[23:16];
    if (s.ext)
    begin
      r.lo_hob = s.lba[31:24];
      r.mid_hob = s.lba[39:32];
      r.hi_hob = s.lba[47:40];
    end
    else
    begin
      r.dev = {s.dev[7:4], s.lba[27:24]};
    end
    return r;
  endfunction : put_addr

  // ----------------------------------------------------------------
  // Abort ending
  // ----------------------------------------------------------------
  function automatic atard_pkg::atard_regs_t do_abort(input atard_pkg::atard_regs_t s);
    atard_pkg::atard_regs_t r;
    r = s;
    r.bsy = 1'b0;
    r.drq = 1'b0;
    r.err = 1'b1;
    r.errreg = `ATARD_ER_ABRT;
    r.intrq = 1'b1;
    r.dmarq = 1'b0;
    r.st = atard_pkg::ATARD_IDLE;
    return r;
  endfunction : do_abort

  // ----------------------------------------------------------------
  // Sector buffer
  // ----------------------------------------------------------------
  atard_sector_buf u_buf (
    .mclk    (mclk),
    .wr_en   (buf_wr),
    .wr_addr (q.wptr),
    .wr_data (media_data),
    .rd_addr (q.rptr),
    .rd_data (buf_word)
  );

  assign buf_wr = (q.st == atard_pkg::ATARD_FETCH) && media_valid && !media_err;
  assign iord_fall = q.iord_s3 && !q.iord_s2;
  assign dmack_on = !q.dmack_s2;
  assign lba28 = {q.dev[3:0], q.hi, q.mid, q.lo};
  assign lba48 = {q.hi_hob, q.mid_hob, q.lo_hob, q.hi, q.mid, q.lo};
  assign qcount = {q.feat_hob, q.feat};
  assign status = {q.bsy, !q.bsy, 2'b00, q.drq, 2'b00, q.err};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    next_q.media_req = 1'b0;
    next_q.flush_req = 1'b0;
    next_q.rdata = 16'h0000;
    next_q.dmack_s1 = dmack_n;
    next_q.dmack_s2 = q.dmack_s1;
    next_q.iord_s1 = iord_n;
    next_q.iord_s2 = q.iord_s1;
    next_q.iord_s3 = q.iord_s2;

    // Register reads
    if (reg_rd)
    begin
      case (reg_addr)
        `ATARD_OFS_DATA:
        begin
          if (q.st == atard_pkg::ATARD_PIO)
          begin
            next_q.rdata = buf_word;
            next_q.rptr = q.rptr + 8'h01;
            if (q.rptr == `ATARD_LAST_WORD)
            begin
              next_q.drq = 1'b0;
              next_q.st = atard_pkg::ATARD_IDLE;
            end
          end
        end
        `ATARD_OFS_FEAT:   next_q.rdata = {8'h00, q.errreg};
        `ATARD_OFS_COUNT:  next_q.rdata = {8'h00, q.cnt};
        `ATARD_OFS_LOW:    next_q.rdata = {8'h00, q.lo};
        `ATARD_OFS_MID:    next_q.rdata = {8'h00, q.mid};
        `ATARD_OFS_HIGH:   next_q.rdata = {8'h00, q.hi};
        `ATARD_OFS_DEVSEL: next_q.rdata = {8'h00, q.dev};
        `ATARD_OFS_CMD:
        begin
          next_q.rdata = {8'h00, status};
          next_q.intrq = 1'b0;
        end
        `ATARD_OFS_CFG:    next_q.rdata = {15'h0000, q.byte8};
        default:           next_q.rdata = 16'h0000;
      endcase
    end

    // Register writes, task file held while busy
    if (reg_wr && !q.bsy)
    begin
      case (reg_addr)
        `ATARD_OFS_FEAT:
        begin
          next_q.feat_hob = q.feat;
          next_q.feat = reg_wdata[7:0];
        end
        `ATARD_OFS_COUNT:
        begin
          next_q.cnt_hob = q.cnt;
          next_q.cnt = reg_wdata[7:0];
        end
        `ATARD_OFS_LOW:
        begin
          next_q.lo_hob = q.lo;
          next_q.lo = reg_wdata[7:0];
        end
        `ATARD_OFS_MID:
        begin
          next_q.mid_hob = q.mid;
          next_q.mid = reg_wdata[7:0];
        end
        `ATARD_OFS_HIGH:
        begin
          next_q.hi_hob = q.hi;
          next_q.hi = reg_wdata[7:0];
        end
        `ATARD_OFS_DEVSEL: next_q.dev = reg_wdata[7:0];
        `ATARD_OFS_CFG:    next_q.byte8 = reg_wdata[`ATARD_CFG_BYTE8];
        `ATARD_OFS_CMD:
        begin
          if (!q.drq)
          begin
            next_q.err = 1'b0;
            next_q.errreg = 8'h00;
            next_q.media_fua = 1'b0;
            next_q.wptr = 8'h00;
            next_q.rptr = 8'h00;
            case (reg_wdata[7:0])
              `ATARD_OP_NOP:
              begin
                next_q = do_abort(next_q);
              end
              `ATARD_OP_RDBUF:
              begin
                next_q.drq = 1'b1;
                next_q.intrq = 1'b1;
                next_q.st = atard_pkg::ATARD_PIO;
              end
              `ATARD_OP_RDDMA:
              begin
                next_q.ext = 1'b0;
                next_q.lba = {20'h00000, lba28};
                next_q.remain = (q.cnt == 8'h00) ? `ATARD_CNT28_ZERO : {9'h000, q.cnt};
                next_q.bsy = 1'b1;
                next_q.media_req = 1'b1;
                next_q.st = atard_pkg::ATARD_FETCH;
              end
              `ATARD_OP_RDDMAX:
              begin
                if (q.byte8)
                begin
                  next_q = do_abort(next_q);
                end
                else
                begin
                  next_q.ext = 1'b1;
                  next_q.lba = lba48;
                  next_q.remain = ({q.cnt_hob, q.cnt} == 16'h0000) ? `ATARD_CNT48_ZERO
                                                                    : {1'b0, q.cnt_hob, q.cnt};
                  next_q.bsy = 1'b1;
                  next_q.media_req = 1'b1;
                  next_q.st = atard_pkg::ATARD_FETCH;
                end
              end
              `ATARD_OP_RDFPDMA:
              begin
                next_q.ext = 1'b1;
                next_q.lba = lba48;
                next_q.remain = (qcount == 16'h0000) ? `ATARD_CNT48_ZERO : {1'b0, qcount};
                next_q.bsy = 1'b1;
                next_q.media_fua = q.dev[`ATARD_DEV_FUA];
                if (q.dev[`ATARD_DEV_FUA])
                begin
                  next_q.flush_req = 1'b1;
                  next_q.st = atard_pkg::ATARD_FLUSH;
                end
                else
                begin
                  next_q.media_req = 1'b1;
                  next_q.st = atard_pkg::ATARD_FETCH;
                end
              end
              default:
              begin
                next_q = do_abort(next_q);
              end
            endcase
          end
        end
        default:
        begin
          next_q.errreg = next_q.errreg;
        end
      endcase
    end

    // Command sequencing
    case (q.st)
      atard_pkg::ATARD_IDLE:
      begin
        next_q.dd_oe = 1'b0;
      end
      atard_pkg::ATARD_PIO:
      begin
        next_q.dd_oe = 1'b0;
      end
      atard_pkg::ATARD_FLUSH:
      begin
        if (flush_done)
        begin
          next_q.media_req = 1'b1;
          next_q.st = atard_pkg::ATARD_FETCH;
        end
      end
      atard_pkg::ATARD_FETCH:
      begin
        next_q.dd_oe = 1'b0;
        if (media_err)
        begin
          next_q = put_addr(next_q);
          next_q.bsy = 1'b0;
          next_q.drq = 1'b0;
          next_q.err = 1'b1;
          next_q.errreg = `ATARD_ER_UNC;
          next_q.intrq = 1'b1;
          next_q.st = atard_pkg::ATARD_IDLE;
        end
        else if (media_valid)
        begin
          next_q.wptr = q.wptr + 8'h01;
          if (q.wptr == `ATARD_LAST_WORD)
          begin
            next_q.rptr = 8'h00;
            next_q.dmarq = 1'b1;
            next_q.drq = 1'b1;
            next_q.bsy = 1'b0;
            next_q.st = atard_pkg::ATARD_XFER;
          end
        end
      end
      atard_pkg::ATARD_XFER:
      begin
        next_q.dd_oe = dmack_on;
        if (dmack_on && iord_fall)
        begin
          next_q.dd_out = buf_word;
          next_q.rptr = q.rptr + 8'h01;
          if (q.rptr == `ATARD_LAST_WORD)
          begin
            next_q.dmarq = 1'b0;
            next_q.remain = q.remain - 17'h00001;
            if (q.remain == 17'h00001)
            begin
              next_q = put_addr(next_q);
              next_q.bsy = 1'b0;
              next_q.drq = 1'b0;
              next_q.intrq = 1'b1;
              next_q.st = atard_pkg::ATARD_IDLE;
            end
            else
            begin
              next_q.lba = q.lba + 48'h000000000001;
              next_q.wptr = 8'h00;
              next_q.bsy = 1'b1;
              next_q.drq = 1'b0;
              next_q.media_req = 1'b1;
              next_q.st = atard_pkg::ATARD_FETCH;
            end
          end
        end
      end
      default:
      begin
        next_q.st = atard_pkg::ATARD_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      q <= '0;
      q.st <= atard_pkg::ATARD_IDLE;
      q.dev <= `ATARD_RST_DEVSEL;
      q.dmack_s1 <= 1'b1;
      q.dmack_s2 <= 1'b1;
      q.iord_s1 <= 1'b1;
      q.iord_s2 <= 1'b1;
      q.iord_s3 <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = q.rdata;
  assign intrq = q.intrq;
  assign dmarq = q.dmarq;
  assign dd_out = q.dd_out;
  assign dd_oe = q.dd_oe;
  assign media_req = q.media_req;
  assign media_lba = q.lba;
  assign media_fua = q.media_fua;
  assign flush_req = q.flush_req;
  assign busy = q.bsy;

endmodule : atard_read_cmd

// ### include/atard_cfg.svh
// Register offsets, field positions, opcodes and reset values of the read command block
`ifndef ATARD_CFG_SVH
`define ATARD_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ATARD_OFS_DATA   4'h0
`define ATARD_OFS_FEAT   4'h1
`define ATARD_OFS_COUNT  4'h2
`define ATARD_OFS_LOW    4'h3
`define ATARD_OFS_MID    4'h4
`define ATARD_OFS_HIGH   4'h5
`define ATARD_OFS_DEVSEL 4'h6
`define ATARD_OFS_CMD    4'h7
`define ATARD_OFS_CFG    4'h8

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define ATARD_OP_NOP     8'h00
`define ATARD_OP_RDBUF   8'he4
`define ATARD_OP_RDDMA   8'hc8
`define ATARD_OP_RDDMAX  8'h25
`define ATARD_OP_RDFPDMA 8'h60

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ATARD_ST_BSY     7
`define ATARD_ST_DRDY    6
`define ATARD_ST_DRQ     3
`define ATARD_ST_ERR     0
`define ATARD_ER_ABRT    8'h04
`define ATARD_ER_UNC     8'h40
`define ATARD_DEV_FUA    7
`define ATARD_CFG_BYTE8  0

// ----------------------------------------------------------------
// Counts and reset values
// ----------------------------------------------------------------
`define ATARD_LAST_WORD  8'hff
`define ATARD_CNT28_ZERO 17'h00100
`define ATARD_CNT48_ZERO 17'h10000
`define ATARD_RST_BYTE   8'h00
`define ATARD_RST_DEVSEL 8'ha0

`endif

// ### include/atard_pkg.sv
// Types of the read command block
package atard_pkg;

  typedef enum logic [2:0] {
    ATARD_IDLE,
    ATARD_PIO,
    ATARD_FLUSH,
    ATARD_FETCH,
    ATARD_XFER
  } atard_state_t;

  typedef struct packed {
    atard_state_t st;
    logic [7:0]   feat;
    logic [7:0]   feat_hob;
    logic [7:0]   cnt;
    logic [7:0]   cnt_hob;
    logic [7:0]   lo;
    logic [7:0]   lo_hob;
    logic [7:0]   mid;
    logic [7:0]   mid_hob;
    logic [7:0]   hi;
    logic [7:0]   hi_hob;
    logic [7:0]   dev;
    logic         byte8;
    logic         bsy;
    logic         drq;
    logic         err;
    logic [7:0]   errreg;
    logic         intrq;
    logic         ext;
    logic [47:0]  lba;
    logic [16:0]  remain;
    logic [7:0]   wptr;
    logic [7:0]   rptr;
    logic         dmarq;
    logic [15:0]  dd_out;
    logic         dd_oe;
    logic         media_req;
    logic         media_fua;
    logic         flush_req;
    logic [15:0]  rdata;
    logic         dmack_s1;
    logic         dmack_s2;
    logic         iord_s1;
    logic         iord_s2;
    logic         iord_s3;
  } atard_regs_t;

endpackage : atard_pkg

// ### src/atard_sector_buf.sv
// Sector buffer of one 512-byte sector, word wide
`timescale 1ns/1ps
module atard_sector_buf (
  input  wire logic        mclk,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic [7:0]  rd_addr,
  output logic      [15:0] rd_data
);

  logic [15:0] mem [0:255];

  // ----------------------------------------------------------------
  // Write port and read port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : atard_sector_buf

// ### sim/atard_read_cmd_assertions.sv
// Assertion checker of the read command interpreter
`timescale 1ns/1ps
`include "atard_cfg.svh"
module atard_chk (
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        intrq,
  input wire logic        dmarq,
  input wire logic        dmack_n,
  input wire logic        iord_n,
  input wire logic [15:0] dd_out,
  input wire logic        dd_oe,
  input wire logic        media_req,
  input wire logic [47:0] media_lba,
  input wire logic        media_fua,
  input wire logic        media_valid,
  input wire logic [15:0] media_data,
  input wire logic        media_err,
  input wire logic        flush_req,
  input wire logic        flush_done,
  input wire logic        busy
);
  logic        byte8_q;
  logic        pend_q;
  logic [47:0] plev_q;
  wire logic   cmd_w = reg_wr && reg_addr == `ATARD_OFS_CMD && !busy;
  wire logic   nop_w = cmd_w && reg_wdata[7:0] == `ATARD_OP_NOP;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  // ---------------------------
  // Helper state
  // ---------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      byte8_q <= 1'b0;
      pend_q  <= 1'b0;
      plev_q  <= 48'h000000000000;
    end
    else
    begin
      if (reg_wr && reg_addr == `ATARD_OFS_CFG)
        byte8_q <= reg_wdata[`ATARD_CFG_BYTE8];
      if (flush_req)
        pend_q <= 1'b1;
      else if (flush_done)
        pend_q <= 1'b0;
      if (media_req)
        plev_q <= media_lba;
    end
  end
  // ---------------------------
  // Properties
  // ---------------------------
  property p_nop_abort;
    nop_w |=> intrq && !busy && !dmarq;
  endproperty
  a_nop_abort: assert property (p_nop_abort) else $error("abort not reported");
  property p_nop_nodata;
    nop_w |=> !media_req [*4];
  endproperty
  a_nop_nodata: assert property (p_nop_nodata) else $error("media fetched on no-op");
  property p_ext_byte8;
    cmd_w && reg_wdata[7:0] == `ATARD_OP_RDDMAX && byte8_q |=> intrq && !busy && !media_req;
  endproperty
  a_ext_byte8: assert property (p_ext_byte8) else $error("ext read not aborted");
  property p_dma_start;
    cmd_w && reg_wdata[7:0] == `ATARD_OP_RDDMA |=> busy && media_req;
  endproperty
  a_dma_start: assert property (p_dma_start) else $error("read did not start");
  property p_dmarq_hold;
    dmarq && dmack_n |=> dmarq;
  endproperty
  a_dmarq_hold: assert property (p_dmarq_hold) else $error("request dropped");
  property p_irq_end;
    $rose(intrq) |-> !busy && !dmarq;
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("interrupt mid transfer");
  property p_lba_step;
    media_req && !$past(reg_wr) && !$past(flush_done) |-> media_lba == plev_q + 48'h000000000001;
  endproperty
  a_lba_step: assert property (p_lba_step) else $error("sector not consecutive");
  property p_fua_order;
    media_req |-> !pend_q;
  endproperty
  a_fua_order: assert property (p_fua_order) else $error("fetch before flush");
  property p_oe_idle;
    dmack_n [*5] |-> !dd_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data driven unacknowledged");
  c_nop: cover property (nop_w);
  c_err: cover property (media_err ##1 intrq);
  c_flush: cover property (flush_done ##1 media_req);
endmodule : atard_chk

bind atard_read_cmd atard_chk u_chk (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .intrq(intrq), .dmarq(dmarq), .dmack_n(dmack_n),
  .iord_n(iord_n), .dd_out(dd_out), .dd_oe(dd_oe), .media_req(media_req), .media_lba(media_lba),
  .media_fua(media_fua), .media_valid(media_valid), .media_data(media_data), .media_err(media_err),
  .flush_req(flush_req), .flush_done(flush_done), .busy(busy));

// ### sim/atard_host_model.sv
// Host DMA model: acknowledges requests, strobes one word at a time
`timescale 1ns/1ps
module atard_host_model (
  input  wire logic        mclk,
  input  wire logic        dmarq,
  input  wire logic [15:0] dd_out,
  input  wire logic        slow,
  output logic             dmack_n,
  output logic             iord_n,
  output logic      [15:0] word,
  output logic             got
);
  logic rq = 1'b0;
  initial
  begin
    dmack_n = 1'b1;
    iord_n = 1'b1;
    word = 16'h0000;
    got = 1'b0;
  end
  always @(negedge mclk)
    rq <= dmarq;
  always
  begin
    @(posedge mclk);
    if (rq)
    begin
      repeat (slow ? 30 : 1) @(posedge mclk);
      dmack_n <= 1'b0;
      repeat (4) @(posedge mclk);
      while (rq)
      begin
        iord_n <= 1'b0;
        repeat (6) @(posedge mclk);
        iord_n <= 1'b1;
        word <= dd_out;
        got <= 1'b1;
        @(posedge mclk);
        got <= 1'b0;
        repeat (5) @(posedge mclk);
      end
      dmack_n <= 1'b1;
    end
  end
endmodule : atard_host_model

// ### sim/testbench.sv
// Self-checking bench of the read command interpreter
`timescale 1ns/1ps
`include "atard_cfg.svh"
module testbench;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        media_valid = 1'b0;
  logic        media_err = 1'b0;
  logic        flush_done = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] media_data = 16'h0000;
  logic [15:0] reg_rdata, dd_out, word, salt;
  logic        intrq, dmarq, dmack_n, iord_n, dd_oe, media_req, media_fua, flush_req, busy, got, mr, fr;
  logic [47:0] media_lba;
  logic [47:0] err_lba = 48'hffffffffffff;
  logic [7:0]  nfl = 8'h00;
  logic [15:0] rxq[$];
  logic [47:0] lbaq[$];
  logic [8:0]  fuaq[$];
  integer      seed = 32'h3974;
  int          errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #12.5 mclk = ~mclk;
  atard_read_cmd dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .intrq(intrq), .dmarq(dmarq), .dmack_n(dmack_n), .iord_n(iord_n),
    .dd_out(dd_out), .dd_oe(dd_oe), .media_req(media_req), .media_lba(media_lba), .media_fua(media_fua),
    .media_valid(media_valid), .media_data(media_data), .media_err(media_err), .flush_req(flush_req),
    .flush_done(flush_done), .busy(busy));
  atard_host_model host (.mclk(mclk), .dmarq(dmarq), .dd_out(dd_out), .slow(slow), .dmack_n(dmack_n),
    .iord_n(iord_n), .word(word), .got(got));
  function automatic logic [15:0] pat(input logic [47:0] l, input logic [7:0] i);
    return l[15:0] ^ {i, ~i} ^ salt;
  endfunction : pat
  task automatic finish_test;
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= {8'h00, d};
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic chkr(input logic [3:0] a, input logic [7:0] e, input string nm);
    logic [15:0] d;
    rd(a, d);
    chk(nm, d[7:0], e);
  endtask : chkr
  task automatic wait_irq;
    for (int k = 0; k < 20000 && intrq !== 1'b1; k++)
      @(negedge mclk);
    chk("intrq", intrq, 1'b1);
  endtask : wait_irq
  task automatic run(input logic [7:0] op, input logic [47:0] l, input logic [15:0] n, input logic [7:0] dv);
    logic [47:0] d;
    logic [47:0] last;
    logic [15:0] full;
    logic [3:0]  ca;
    ca = (op == `ATARD_OP_RDFPDMA) ? `ATARD_OFS_FEAT : `ATARD_OFS_COUNT;
    d = err_lba - l;
    full = (d < {32'h0, n}) ? d[15:0] : n;
    last = (full == n) ? l + n - 1 : err_lba;
    wr(ca, n[15:8]);
    wr(ca, n[7:0]);
    for (int b = 0; b < 3; b++)
    begin
      wr(`ATARD_OFS_HIGH - b[3:0], l[47 - 8 * b -: 8]);
      wr(`ATARD_OFS_HIGH - b[3:0], l[23 - 8 * b -: 8]);
    end
    wr(`ATARD_OFS_DEVSEL, dv);
    rxq.delete();
    lbaq.delete();
    fuaq.delete();
    nfl = 8'h00;
    slow <= seed[5];
    wr(`ATARD_OFS_CMD, op);
    wait_irq;
    repeat (16) @(posedge mclk);
    chkr(`ATARD_OFS_CMD, (full == n) ? 8'h40 : 8'h41, "status");
    if (full != n)
      chkr(`ATARD_OFS_FEAT, `ATARD_ER_UNC, "error");
    chk("words", rxq.size(), 256 * full);
    foreach (rxq[k])
      chk("data", rxq[k], pat(l + k / 256, k[7:0]));
    foreach (lbaq[k])
      chk("sector", lbaq[k], l + k);
    for (int b = 0; b < 3; b++)
      chkr(`ATARD_OFS_LOW + b[3:0], last[8 * b +: 8], "address");
  endtask : run
  always @(negedge mclk)
  begin
    mr <= media_req;
    fr <= flush_req;
  end
  always
  begin
    @(posedge mclk);
    if (fr)
    begin
      nfl <= nfl + 8'h01;
      repeat (4) @(posedge mclk);
      flush_done <= 1'b1;
      @(posedge mclk);
      flush_done <= 1'b0;
    end
    if (mr)
    begin
      lbaq.push_back(media_lba);
      fuaq.push_back({media_fua, nfl});
      for (int i = 0; i < 256 && media_err !== 1'b1; i++)
      begin
        media_valid <= media_lba !== err_lba || i < 10;
        media_err <= media_lba === err_lba && i == 10;
        media_data <= pat(media_lba, i[7:0]);
        @(posedge mclk);
      end
      media_valid <= 1'b0;
      media_err <= 1'b0;
    end
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (got)
      rxq.push_back(word);
    if (cyc == 60000)
    begin
      errors = errors + 1;
      finish_test;
    end
  end
  initial
  begin
    logic [31:0] r;
    logic [15:0] w;
    salt = $random(seed);
    r = $random(seed);
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    chkr(`ATARD_OFS_DEVSEL, `ATARD_RST_DEVSEL, "devsel");
    chkr(`ATARD_OFS_CMD, 8'h40, "status");
    chkr(4'hf, 8'h00, "unmapped");
    wr(`ATARD_OFS_CMD, `ATARD_OP_NOP);
    wait_irq;
    chkr(`ATARD_OFS_CMD, 8'h41, "status");
    chkr(`ATARD_OFS_FEAT, `ATARD_ER_ABRT, "error");
    wr(`ATARD_OFS_CFG, 8'h01);
    wr(`ATARD_OFS_CMD, `ATARD_OP_RDDMAX);
    wait_irq;
    chkr(`ATARD_OFS_FEAT, `ATARD_ER_ABRT, "error");
    chkr(`ATARD_OFS_CMD, 8'h41, "status");
    chk("nodata", lbaq.size(), 0);
    wr(`ATARD_OFS_CFG, 8'h00);
    run(`ATARD_OP_RDDMA, {20'h0, r[27:0]}, 16'h0002, {4'he, r[27:24]});
    wr(`ATARD_OFS_CMD, `ATARD_OP_RDBUF);
    wait_irq;
    chkr(`ATARD_OFS_CMD, 8'h48, "status");
    for (int k = 0; k < 256; k++)
    begin
      rd(`ATARD_OFS_DATA, w);
      chk("buffer", w, pat({20'h0, r[27:0]} + 1, k[7:0]));
    end
    chkr(`ATARD_OFS_CMD, 8'h40, "status");
    chk("nomedia", lbaq.size(), 2);
    err_lba = {20'h0, r[27:0]} + 1;
    run(`ATARD_OP_RDDMA, {20'h0, r[27:0]}, 16'h0003, {4'he, r[27:24]});
    err_lba = 48'hffffffffffff;
    r = $random(seed);
    run(`ATARD_OP_RDDMAX, {r[15:0], r}, 16'h0001, 8'h40);
    run(`ATARD_OP_RDFPDMA, {16'h0, r}, 16'h0001, 8'hc0);
    chk("forced", fuaq[0], 9'h101);
    run(`ATARD_OP_RDFPDMA, {16'h0, r} + 48'h2, 16'h0001, 8'h40);
    chk("cached", fuaq[0], 9'h000);
    finish_test;
  end
endmodule : testbench
